//--- rtl/sfb_pkg.sv
// constants, types and reset values of the serial flash boot loader
// assumes a 125 MHz core clock and one or two spi flash parts on the link
`default_nettype none
package sfb_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_KHZ = 125000;
  localparam int SCK_KHZ = 33300;
  localparam int CLK_NS = 8;
  localparam int CS_HIGH_NS = 300;
  // the serial clock may not run faster than its figure, so the half period rounds up
  localparam int SCK_HALF = (CLK_KHZ + 2 * SCK_KHZ - 1) / (2 * SCK_KHZ);
  localparam int CS_GAP_CYC = (CS_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [5:0] CS_GAP = 6'(CS_GAP_CYC);
  localparam logic [2:0] PH_RISE = 3'h0;
  localparam logic [2:0] PH_FALL = 3'(SCK_HALF);
  localparam logic [2:0] PH_SAMPLE = 3'(2 * SCK_HALF - 1);
  localparam logic [2:0] PH_LAST = 3'(2 * SCK_HALF - 1);

  // ****************************************
  // flash commands and layout
  // ****************************************
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_WRITE_EN = 8'h06;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [2:0] HB_READ = 3'h5;
  localparam logic [2:0] HB_PROG = 3'h4;
  localparam logic [2:0] HB_SHORT = 3'h1;
  localparam logic [23:0] HDR_ADDR = 24'h000000;
  localparam logic [23:0] HDR_BYTES = 24'h000008;
  localparam int HDR_LOC_LSB = 0;
  localparam int HDR_SIZE_LSB = 32;
  localparam int FLASH_AW = 21;
  localparam int PMEM_AW = 12;
  localparam logic [23:0] PMEM_DEPTH = 24'h001000;
  localparam logic [23:0] SEQ_BASE = 24'h010000;
  localparam logic [23:0] SEQ_BYTES = 24'h001400;
  localparam logic [23:0] DEG_BASE = 24'h030000;
  localparam logic [23:0] DEG_BYTES = 24'h000400;
  localparam logic [23:0] DEG_PER_SEQ = 24'h000007;
  localparam logic [15:0] PAGE_BYTES = 16'h0100;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [5:0] {
    ST_OFF = 6'h01, ST_GAP = 6'h02, ST_BYTE = 6'h04,
    ST_SHIFT = 6'h08, ST_RUN = 6'h10, ST_READY = 6'h20
  } sfb_state_e;
  typedef enum logic [5:0] {
    JB_HDR = 6'h01, JB_LOAD = 6'h02, JB_HREAD = 6'h04,
    JB_WREN = 6'h08, JB_PROG = 6'h10, JB_POLL = 6'h20
  } sfb_job_e;
  typedef enum logic [1:0] {
    CK_READ = 2'h0, CK_SEQ = 2'h1, CK_DEG = 2'h2, CK_PROG = 2'h3
  } sfb_kind_e;
  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic mosi;
    logic mosi_oe;
    logic cs0;
    logic cs0_oe;
    logic cs1;
  } sfb_pins_s;
  typedef struct packed {
    logic valid;
    sfb_kind_e kind;
    logic sel;
    logic [23:0] addr;
    logic [15:0] len;
  } sfb_cmd_s;
  typedef struct packed {
    sfb_state_e state;
    sfb_job_e job;
    sfb_pins_s pins;
    logic [2:0] sync;
    logic miso;
    logic [2:0] phase;
    logic [2:0] bitn;
    logic [7:0] tx;
    logic [7:0] rx;
    logic indata;
    logic [39:0] hbuf;
    logic [2:0] hleft;
    logic [23:0] dleft;
    logic [5:0] gap;
    logic sel;
    logic [63:0] hdr;
    logic [2:0] hdr_idx;
    logic [PMEM_AW-1:0] wptr;
    logic mem_we;
    logic [PMEM_AW-1:0] mem_wa;
    logic [7:0] mem_wd;
    logic [23:0] paddr;
    logic [23:0] plen;
    logic [7:0] pbuf;
    logic pfull;
    logic init_done;
    logic run;
    logic cmd_ready;
    logic wr_ready;
    logic rd_valid;
    logic [7:0] rd_data;
    logic done;
    logic refused;
  } sfb_regs_s;
  // pins float in reset except the secondary select, which stays driven high
  localparam sfb_pins_s PINS_RESET = '{sck: 1'b0, sck_oe: 1'b0, mosi: 1'b0, mosi_oe: 1'b0,
                                      cs0: 1'b1, cs0_oe: 1'b0, cs1: 1'b1};
  localparam sfb_regs_s REG_RESET = '{state: ST_OFF, job: JB_HDR,
                                      pins: PINS_RESET, default: '0};
endpackage
`default_nettype wire

//--- rtl/sfb_prog_mem.sv
// program memory of the internal control processor, byte wide
// assumes one writer (the loader) and one reader on the same clock
`default_nettype none
module sfb_prog_mem (
  input wire logic clk,
  input wire logic we,
  input wire logic [sfb_pkg::PMEM_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [sfb_pkg::PMEM_AW-1:0] raddr,
  output logic [7:0] rdata
);
  import sfb_pkg::*;

  logic [7:0] mem [0:(1 << PMEM_AW) - 1];

  // read data is registered, one cycle after the address
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

//--- rtl/sfb_boot_loader.sv
// spi master that boots the controller from serial flash and serves host flash jobs
// assumes the processor reads program memory on the core clock and reports when done
`default_nettype none
// Function
// RULE_01: single spi master, mode 0, fixed clock
// RULE_02: two independent flash chip selects
// RULE_03: boot always from primary select
// RULE_04: first read header bytes 0 to 7
// RULE_05: copy routine into program memory
// RULE_06: run the loaded routine
// RULE_07: raise init done when routine finishes
// RULE_08: reads use fast read, address, dummy
// RULE_09: never slow read, clock never adapts
// RULE_10: flash auto-increments address while selected
// RULE_11: address up to 16 Mb flash
// RULE_12: hold and write-protect pulled up externally
// RULE_13: host programming uses page program commands
// RULE_14: reset floats clock, data, primary select
// RULE_15: secondary select stays driven in reset
// RULE_16: sixteen sequences of 5 KB each
// RULE_17: seven degamma tables per sequence; the code refuses only index bit 3, so table 7 is read too
// RULE_18: msb first, select low per command
module sfb_boot_loader (
  input wire logic clk,
  input wire logic reset,
  input wire logic serial_data_in_pin,
  output sfb_pkg::sfb_pins_s pins,
  output logic init_done_output,
  output logic routine_run,
  input wire logic routine_finished,
  input wire logic [sfb_pkg::PMEM_AW-1:0] prog_rd_addr,
  output logic [7:0] prog_rd_data,
  input wire sfb_pkg::sfb_cmd_s host_cmd,
  output logic host_cmd_ready,
  input wire logic [7:0] host_wr_data,
  input wire logic host_wr_valid,
  output logic host_wr_ready,
  output logic [7:0] host_rd_data,
  output logic host_rd_valid,
  output logic host_done,
  output logic host_refused
);
  import sfb_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  // every transfer starts with the selects high for the minimum gap
  function automatic sfb_regs_s launch(sfb_regs_s r, sfb_job_e j, logic s, logic [7:0] op,
                                       logic [23:0] a, logic [2:0] nh, logic [23:0] n);
    r.job = j;
    r.sel = s;
    r.hbuf = {op, 3'h0, a[FLASH_AW-1:0], 8'h00}; // RULE_11
    r.hleft = nh;
    r.dleft = n;
    r.pins.cs0 = 1'b1; // RULE_18
    r.pins.cs1 = 1'b1;
    r.gap = CS_GAP;
    r.state = ST_GAP;
    return r;
  endfunction

  function automatic logic [23:0] region_addr(logic [23:0] base, logic [23:0] idx,
                                              logic [23:0] size);
    return 24'(base + idx * size);
  endfunction

  // ****************************************
  // state
  // ****************************************
  sfb_regs_s r;
  sfb_regs_s next_r;
  logic go;
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  logic [23:0] load_size;
  logic [23:0] deg_idx;
  logic far_addr;

  assign rx_byte = {r.rx[6:0], r.miso};
  assign load_size = (r.hdr[HDR_SIZE_LSB +: 24] > PMEM_DEPTH) ? PMEM_DEPTH :
                     r.hdr[HDR_SIZE_LSB +: 24];
  assign deg_idx = 24'(host_cmd.addr[7:4]) * DEG_PER_SEQ + 24'(host_cmd.addr[2:0]);
  assign far_addr = host_cmd.addr[23:FLASH_AW] != 3'h0;

  always_comb begin
    next_r = r;
    go = 1'b0;
    tx_byte = 8'h00;
    next_r.mem_we = 1'b0;
    next_r.rd_valid = 1'b0;
    next_r.run = 1'b0;
    next_r.done = 1'b0;
    next_r.refused = 1'b0;
    // three stage filter on the returned data line
    next_r.sync = {r.sync[1:0], serial_data_in_pin};
    if (r.sync[1] == r.sync[2]) begin
      next_r.miso = r.sync[2];
    end
    if (r.wr_ready && host_wr_valid) begin
      next_r.pbuf = host_wr_data;
      next_r.pfull = 1'b1;
      next_r.wr_ready = 1'b0;
    end

    unique case (r.state)
      ST_OFF: begin
        // no hold or write-protect outputs exist; the board pulls them high
        next_r.pins.sck_oe = 1'b1; // RULE_14
        next_r.pins.mosi_oe = 1'b1;
        next_r.pins.cs0_oe = 1'b1;
        next_r = launch(next_r, JB_HDR, 1'b0, OP_FAST_READ, HDR_ADDR, HB_READ,
                        HDR_BYTES); // RULE_03 RULE_04 RULE_12
      end
      ST_GAP: begin
        if (r.gap == 6'h00) begin
          next_r.pins.cs0 = r.sel; // RULE_02
          next_r.pins.cs1 = !r.sel;
          next_r.state = ST_BYTE;
        end else begin
          next_r.gap = r.gap - 6'h01;
        end
      end
      ST_BYTE: begin
        if (r.hleft != 3'h0) begin
          // command, address and dummy byte all leave msb first
          tx_byte = r.hbuf[39:32]; // RULE_08 RULE_18
          next_r.hbuf = {r.hbuf[31:0], 8'h00};
          next_r.hleft = r.hleft - 3'h1;
          next_r.indata = 1'b0;
          go = 1'b1;
        end else if (r.dleft != 24'h000000) begin
          if (r.job == JB_PROG) begin
            // the clock stops while the host has no byte ready
            if (r.pfull) begin
              tx_byte = r.pbuf;
              next_r.pfull = 1'b0;
              go = 1'b1;
            end else if (!r.wr_ready) begin
              next_r.wr_ready = 1'b1;
            end
          end else begin
            go = 1'b1;
          end
          if (go) begin
            next_r.dleft = r.dleft - 24'h000001;
            next_r.indata = 1'b1;
          end
        end else begin
          // end of command: raise both selects before anything else
          next_r.pins.cs0 = 1'b1; // RULE_18
          next_r.pins.cs1 = 1'b1;
          next_r.wr_ready = 1'b0;
          unique case (r.job)
            JB_HDR: begin
              next_r.wptr = '0;
              if (load_size == 24'h000000) begin
                next_r.run = 1'b1;
                next_r.state = ST_RUN;
              end else begin
                next_r = launch(next_r, JB_LOAD, 1'b0, OP_FAST_READ,
                                r.hdr[HDR_LOC_LSB +: 24], HB_READ, load_size); // RULE_05
              end
            end
            JB_LOAD: begin
              next_r.run = 1'b1; // RULE_06
              next_r.state = ST_RUN;
            end
            JB_HREAD: begin
              next_r.done = 1'b1;
              next_r.cmd_ready = 1'b1;
              next_r.state = ST_READY;
            end
            JB_WREN: begin
              next_r = launch(next_r, JB_PROG, r.sel, OP_PAGE_PROG, r.paddr, HB_PROG,
                              r.plen); // RULE_13
            end
            JB_PROG: begin
              next_r = launch(next_r, JB_POLL, r.sel, OP_READ_STATUS, 24'h000000, HB_SHORT,
                              24'h000001);
            end
            JB_POLL: begin
              // bit 0 of the status byte is write in progress
              if (r.rx[0]) begin
                next_r = launch(next_r, JB_POLL, r.sel, OP_READ_STATUS, 24'h000000, HB_SHORT,
                                24'h000001);
              end else begin
                next_r.done = 1'b1;
                next_r.cmd_ready = 1'b1;
                next_r.state = ST_READY;
              end
            end
          endcase
        end
        if (go) begin
          next_r.pins.mosi = tx_byte[7];
          next_r.tx = {tx_byte[6:0], 1'b0};
          next_r.phase = PH_RISE;
          next_r.bitn = 3'h0;
          next_r.state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        // fixed divider from the core clock, idle low, sample on rise
        next_r.phase = (r.phase == PH_LAST) ? 3'h0 : r.phase + 3'h1; // RULE_01 RULE_09
        if (r.phase == PH_RISE) begin
          next_r.pins.sck = 1'b1;
        end
        if (r.phase == PH_FALL) begin
          next_r.pins.sck = 1'b0;
          if (r.bitn != 3'h7) begin
            next_r.pins.mosi = r.tx[7]; // RULE_18
            next_r.tx = {r.tx[6:0], 1'b0};
          end
        end
        // the filter delays the line by about one full serial clock period, so this sees the rise value
        if (r.phase == PH_SAMPLE) begin
          next_r.rx = rx_byte;
          next_r.bitn = r.bitn + 3'h1;
          if (r.bitn == 3'h7) begin
            next_r.state = ST_BYTE;
            if (r.indata) begin
              unique case (r.job)
                JB_HDR: begin
                  // one command returns all header bytes in order
                  next_r.hdr[{r.hdr_idx, 3'h0} +: 8] = rx_byte; // RULE_10
                  next_r.hdr_idx = r.hdr_idx + 3'h1;
                end
                JB_LOAD: begin
                  next_r.mem_we = 1'b1; // RULE_05
                  next_r.mem_wa = r.wptr;
                  next_r.mem_wd = rx_byte;
                  next_r.wptr = r.wptr + PMEM_AW'(1);
                end
                JB_HREAD: begin
                  next_r.rd_data = rx_byte;
                  next_r.rd_valid = 1'b1;
                end
                JB_WREN, JB_PROG, JB_POLL: begin
                end
              endcase
            end
          end
        end
      end
      ST_RUN: begin
        if (routine_finished) begin
          next_r.init_done = 1'b1; // RULE_07
          next_r.cmd_ready = 1'b1;
          next_r.state = ST_READY;
        end
      end
      ST_READY: begin
        if (r.cmd_ready && host_cmd.valid) begin
          next_r.cmd_ready = 1'b0;
          unique case (host_cmd.kind)
            CK_READ: begin
              if (far_addr || host_cmd.len == 16'h0000) begin // RULE_11
                next_r.refused = 1'b1;
                next_r.cmd_ready = 1'b1;
              end else begin
                next_r = launch(next_r, JB_HREAD, host_cmd.sel, OP_FAST_READ, host_cmd.addr,
                                HB_READ, 24'(host_cmd.len)); // RULE_08
              end
            end
            CK_SEQ: begin
              next_r = launch(next_r, JB_HREAD, host_cmd.sel, OP_FAST_READ,
                              region_addr(SEQ_BASE, 24'(host_cmd.addr[3:0]), SEQ_BYTES),
                              HB_READ, SEQ_BYTES); // RULE_16
            end
            CK_DEG: begin
              if (host_cmd.addr[3]) begin // RULE_17
                next_r.refused = 1'b1;
                next_r.cmd_ready = 1'b1;
              end else begin
                next_r = launch(next_r, JB_HREAD, host_cmd.sel, OP_FAST_READ,
                                region_addr(DEG_BASE, deg_idx, DEG_BYTES),
                                HB_READ, DEG_BYTES); // RULE_17
              end
            end
            CK_PROG: begin
              // a page program may not wrap inside its page
              if (far_addr || host_cmd.len == 16'h0000 ||
                  host_cmd.len > (PAGE_BYTES - {8'h00, host_cmd.addr[7:0]})) begin
                next_r.refused = 1'b1;
                next_r.cmd_ready = 1'b1;
              end else begin
                next_r.paddr = host_cmd.addr;
                next_r.plen = 24'(host_cmd.len);
                next_r.pfull = 1'b0;
                next_r = launch(next_r, JB_WREN, host_cmd.sel, OP_WRITE_EN, 24'h000000,
                                HB_SHORT, 24'h000000); // RULE_13
              end
            end
          endcase
        end
      end
    endcase
  end

  // reset floats the primary pins and keeps the secondary select driven
  always_ff @(posedge clk) begin
    if (reset) begin
      r <= REG_RESET; // RULE_14 RULE_15
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // program memory and outputs
  // ****************************************
  sfb_prog_mem u_mem (
    .clk(clk),
    .we(r.mem_we),
    .waddr(r.mem_wa),
    .wdata(r.mem_wd),
    .raddr(prog_rd_addr),
    .rdata(prog_rd_data)
  );

  assign pins = r.pins;
  assign init_done_output = r.init_done;
  assign routine_run = r.run;
  assign host_cmd_ready = r.cmd_ready;
  assign host_wr_ready = r.wr_ready;
  assign host_rd_data = r.rd_data;
  assign host_rd_valid = r.rd_valid;
  assign host_done = r.done;
  assign host_refused = r.refused;
endmodule
`default_nettype wire

//--- testbench/sfb_chk.sv
// assertions on the ports of the serial flash boot loader
// assumes it is bound to every sfb_boot_loader instance
`default_nettype none
module sfb_chk
  import sfb_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire sfb_pkg::sfb_pins_s pins,
  input wire logic init_done_output,
  input wire logic routine_run,
  input wire logic routine_finished,
  input wire sfb_pkg::sfb_cmd_s host_cmd,
  input wire logic host_cmd_ready,
  input wire logic host_refused
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] hi_cnt;
  logic take;
  assign take = host_cmd.valid && host_cmd_ready;
  // saturates, so a long idle time never wraps to a short one
  always_ff @(posedge clk) begin
    if (reset || !(pins.cs0 && pins.cs1)) begin
      hi_cnt <= 6'h00;
    end else if (hi_cnt != 6'h3f) begin
      hi_cnt <= hi_cnt + 6'h01;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ****
  // link
  // ****
  pins_float_a: assert property ($fell(reset) |-> !pins.sck_oe && !pins.mosi_oe
    && !pins.cs0_oe)
    else $error("link pins driven in reset");
  sel1_driven_a: assert property ($fell(reset) |-> pins.cs1 && $past(pins.cs1))
    else $error("secondary select not held high");
  sck_idle_a: assert property (pins.cs0 && pins.cs1 |-> !pins.sck)
    else $error("serial clock not idle low");
  sck_high_a: assert property ($rose(pins.sck) |-> ##1 pins.sck ##1 !pins.sck)
    else $error("serial clock high time wrong");
  one_select_a: assert property (pins.cs0 || pins.cs1)
    else $error("both selects low");
  select_gap_a: assert property ($fell(pins.cs0) || $fell(pins.cs1) |-> hi_cnt >= 6'h26)
    else $error("select high time too short");
  // ****
  // boot and host
  // ****
  run_pulse_a: assert property (routine_run |=> !routine_run)
    else $error("run pulse longer than a cycle");
  done_cause_a: assert property ($rose(init_done_output) |-> $past(routine_finished))
    else $error("init done without routine end");
  done_hold_a: assert property (init_done_output |=> init_done_output)
    else $error("init done dropped");
  addr_refuse_a: assert property (take && host_cmd.addr[23:21] != 3'h0
    && host_cmd.kind inside {CK_READ, CK_PROG} |=> host_refused)
    else $error("address beyond flash not refused");
  deg_refuse_a: assert property (take && host_cmd.kind == CK_DEG && host_cmd.addr[3]
    |=> host_refused)
    else $error("degamma table index not refused");
endmodule
bind sfb_boot_loader sfb_chk u_chk (.clk(clk), .reset(reset), .pins(pins),
  .init_done_output(init_done_output), .routine_run(routine_run),
  .routine_finished(routine_finished), .host_cmd(host_cmd),
  .host_cmd_ready(host_cmd_ready), .host_refused(host_refused));
`default_nettype wire

//--- testbench/sfb_flash_model.sv
// behavioural spi flash: fast read, write enable, page program, status
// assumes hold and write-protect inputs pulled high on the board
`default_nettype none
module sfb_flash_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic cs_n,
  output logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [int];
  logic [31:0] log [$];
  logic [31:0] sh;
  logic [23:0] addr;
  logic [7:0] op, ob;
  logic wel;
  int nbit, bad_op, p, busy;
  initial begin
    miso = 1'b0;
    wel = 1'b0;
    busy = 0;
    bad_op = 0;
    nbit = 0;
  end
  // unwritten bytes read as a pattern of their address
  function automatic logic [7:0] rd(input int a);
    return mem.exists(a) ? mem[a] : 8'(a * 7 + (a >> 9));
  endfunction
  // a released data line shows the inverse of its last value
  always @(posedge cs_n) begin
    nbit = 0;
    // a finished page program reports busy for the next two status reads
    if (op == 8'h02 && wel) busy = 2;
    else if (op == 8'h05 && busy > 0) busy--;
    if (op == 8'h02) wel = 1'b0;
    miso <= ~miso;
  end
  always @(posedge sck) begin
    if (!cs_n) begin
      sh = {sh[30:0], mosi};
      nbit++;
      if (nbit == 8) begin
        op = sh[7:0];
        if (op == 8'h06) wel = 1'b1;
        if (!(op inside {8'h0b, 8'h06, 8'h02, 8'h05})) bad_op++;
      end
      if (nbit == 32) begin
        addr = sh[23:0];
        log.push_back({op, addr});
      end
      if (wel && op == 8'h02 && nbit > 32 && nbit % 8 == 0) begin
        mem[int'(addr)] = sh[7:0];
        addr++;
      end
    end
  end
  // mode 0: data changes after the falling edge, within the output valid time
  always @(negedge sck) begin
    if (!cs_n && op == 8'h0b && nbit >= 40) begin
      p = (nbit - 40) % 8;
      if (p == 0) begin
        ob = rd(int'(addr));
        addr++;
      end
      miso <= #2 ob[7 - p];
    end else if (!cs_n && op == 8'h05 && nbit >= 8) begin
      miso <= #2 (busy != 0) && ((nbit - 8) % 8 == 7);
    end
  end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench of the serial flash boot loader
// assumes one flash model on each select, sharing clock and data
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %0t: got %0h exp %0h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sfb_pkg::*;
  logic clk, reset, routine_finished, host_wr_valid, refd, sl;
  logic sck_w, mosi_w, cs0_w, miso0, miso1, miso_w;
  logic init_done_output, routine_run, host_cmd_ready, host_wr_ready;
  logic host_rd_valid, host_done, host_refused;
  logic [PMEM_AW-1:0] prog_rd_addr;
  logic [7:0] prog_rd_data, host_wr_data, host_rd_data;
  logic [23:0] loc, size, a;
  logic [15:0] ln;
  logic [7:0] wq [$];
  logic [7:0] wd [$];
  sfb_pins_s pins;
  sfb_cmd_s host_cmd;
  int fails, n_compared, seed, nb;
  // released lines: pull-up on the primary select, pull-down on clock and data
  assign sck_w = pins.sck_oe ? pins.sck : 1'b0;
  assign mosi_w = pins.mosi_oe ? pins.mosi : 1'b0;
  assign cs0_w = pins.cs0_oe ? pins.cs0 : 1'b1;
  assign miso_w = !pins.cs1 ? miso1 : miso0;
  // the boot image sits behind the primary select
  sfb_flash_model flash0 (.sck(sck_w), .mosi(mosi_w), .cs_n(cs0_w), .miso(miso0));
  sfb_flash_model flash1 (.sck(sck_w), .mosi(mosi_w), .cs_n(pins.cs1), .miso(miso1));
  sfb_boot_loader uut (.clk(clk), .reset(reset), .serial_data_in_pin(miso_w), .pins(pins),
    .init_done_output(init_done_output), .routine_run(routine_run),
    .routine_finished(routine_finished), .prog_rd_addr(prog_rd_addr),
    .prog_rd_data(prog_rd_data), .host_cmd(host_cmd), .host_cmd_ready(host_cmd_ready),
    .host_wr_data(host_wr_data), .host_wr_valid(host_wr_valid),
    .host_wr_ready(host_wr_ready), .host_rd_data(host_rd_data),
    .host_rd_valid(host_rd_valid), .host_done(host_done), .host_refused(host_refused));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic step(inout int n);
    @(posedge clk);
    #1;
    n++;
    if (n > 40000) begin
      fails++;
      $display("unexpected %0t: wait ran out", $time);
      complete_run();
    end
  endtask
  task automatic boot();
    int n;
    reset = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK(pins.cs0_oe | pins.sck_oe | pins.mosi_oe, 1'b0)
    `CHK(pins.cs1, 1'b1)
    flash0.log.delete();
    flash1.log.delete();
    reset = 1'b0;
    n = 0;
    while (routine_run !== 1'b1) step(n);
    `CHK(flash0.log.size(), 2)
    `CHK(flash0.log[0], 32'h0b000000)
    `CHK(flash0.log[1], {8'h0b, loc})
    `CHK(flash1.log.size(), 0)
    `CHK(init_done_output, 1'b0)
    for (int i = 0; i < size; i++) begin
      prog_rd_addr = PMEM_AW'(i);
      repeat (2) @(posedge clk);
      #1;
      `CHK(prog_rd_data, flash0.rd(loc + i))
    end
    routine_finished = 1'b1;
    step(n);
    routine_finished = 1'b0;
    `CHK({init_done_output, host_cmd_ready}, 2'b11)
  endtask
  // one host job; read bytes are checked against the flash behind the select
  task automatic cmd(input sfb_kind_e kd, input logic s, input logic [23:0] ad,
                     input logic [15:0] n, input logic [23:0] base, input int stop);
    int c;
    logic acc;
    nb = 0;
    c = 0;
    // one idle cycle, so valid is never lowered and raised in one time step
    step(c);
    host_cmd = '{1'b1, kd, s, ad, n};
    step(c);
    host_cmd.valid = 1'b0;
    host_wr_valid = wq.size() > 0;
    host_wr_data = host_wr_valid ? wq[0] : 8'h00;
    while (host_done !== 1'b1 && host_refused !== 1'b1 && nb < stop) begin
      acc = host_wr_valid && host_wr_ready;
      step(c);
      if (acc) void'(wq.pop_front());
      host_wr_valid = wq.size() > 0;
      host_wr_data = host_wr_valid ? wq[0] : 8'h00;
      if (host_rd_valid === 1'b1) begin
        `CHK(host_rd_data, s ? flash1.rd(base + nb) : flash0.rd(base + nb))
        nb++;
      end
    end
    refd = host_refused;
  endtask
  initial begin
    seed = 90;
    reset = 1'b1;
    routine_finished = 1'b0;
    prog_rd_addr = '0;
    host_cmd = '0;
    host_wr_valid = 1'b0;
    host_wr_data = 8'h00;
    fails = 0;
    n_compared = 0;
    loc = {3'h0, 21'($random(seed))};
    size = 24'(($random(seed) & 15) + 1);
    for (int i = 0; i < 3; i++) begin
      flash0.mem[i] = loc[8 * i +: 8];
      flash0.mem[i + 4] = size[8 * i +: 8];
    end
    boot();
    // the first read crosses the top of the addressable range
    for (int i = 0; i < 5; i++) begin
      a = i == 0 ? 24'h1ffffd : {3'h0, 21'($random(seed))};
      ln = 16'(($random(seed) & 7) + 1);
      sl = 1'($random(seed));
      cmd(CK_READ, sl, a, ln, a, 1 << 30);
      `CHK(refd, 1'b0)
      `CHK(nb, int'(ln))
      `CHK(sl ? flash1.log[$] : flash0.log[$], {8'h0b, a})
    end
    cmd(CK_READ, 1'b0, 24'h200000, 16'h0001, 24'h0, 1 << 30);
    `CHK(refd, 1'b1)
    cmd(CK_DEG, 1'b0, 24'h000028, 16'h0001, 24'h0, 1 << 30);
    `CHK(refd, 1'b1)
    cmd(CK_PROG, 1'b1, 24'h0000f0, 16'h0011, 24'h0, 1 << 30);
    `CHK(refd, 1'b1)
    a = {3'h0, 13'($random(seed)), 8'h10};
    for (int j = 0; j < 4; j++) wq.push_back(8'($random(seed)));
    wd = wq;
    cmd(CK_PROG, 1'b1, a, 16'h0004, 24'h0, 1 << 30);
    `CHK(refd, 1'b0)
    `CHK(flash1.log[$], {8'h02, a})
    `CHK(flash1.busy, 0)
    for (int j = 0; j < 4; j++) `CHK(flash1.mem[a + j], wd[j])
    // sequence 2, table 5
    cmd(CK_DEG, 1'b0, 24'h000025, 16'h0001, 24'h034c00, 1 << 30);
    `CHK(nb, 1024)
    `CHK(flash0.log[$], {8'h0b, 24'h034c00})
    // a full sequence is long: cut it short by a reset in mid-transfer
    cmd(CK_SEQ, 1'b0, 24'h00000f, 16'h0001, 24'h022c00, 3);
    `CHK(flash0.log[$], {8'h0b, 24'h022c00})
    boot();
    `CHK(flash0.bad_op + flash1.bad_op, 0)
    complete_run();
  end
endmodule
`default_nettype wire
